/* design/tcg_timer_group.sv */
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module tcg_timer_group #(
  parameter int PRESC_WIDTH = tcg_pkg::PRESC_WIDTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tcg_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcg_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [tcg_pkg::NUM_CH-1:0] timer_input_pin,
  output logic [tcg_pkg::NUM_CH-1:0] channel_interrupt_request,
  output logic ch1_upper_half_interrupt,
  output logic ch3_upper_half_interrupt
);
  import tcg_pkg::*;
  // The divider must reach a division of 2^15.
  if (PRESC_WIDTH < 15 || PRESC_WIDTH > 31) begin : g_bad_width
    $error("PRESC_WIDTH must lie between 15 and 31.");
  end
  typedef struct packed {
    logic [PRESC_WIDTH-1:0] presc;
    logic [7:0] psel;
    logic [NUM_CH-1:0][15:0] mode;
    logic [NUM_CH-1:0][15:0] data;
    logic [NUM_CH-1:0][15:0] count;
    logic [NUM_CH-1:0][7:0] ucount;
    tcg_phase_type [NUM_CH-1:0] phase;
    tcg_phase_type [NUM_CH-1:0] uphase;
    logic [NUM_CH-1:0] tick_d;
    logic [NUM_CH-1:0] utick_d;
    logic [NUM_CH-1:0] sync1;
    logic [NUM_CH-1:0] sync2;
    logic [NUM_CH-1:0] prv;
    logic [NUM_CH-1:0] acc;
    logic [NUM_CH-1:0] acc_d;
    logic [NUM_CH-1:0] irq;
    logic [NUM_CH-1:0] uirq;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcg_state_type;
  tcg_state_type st_reg;
  tcg_state_type st_next;
  // Divider tap: sel 0 gives a tick every cycle, sel k one in 2^k.
  function automatic logic prescale_hit(input logic [PRESC_WIDTH-1:0] cnt,
                                        input logic [3:0] sel);
    logic [PRESC_WIDTH-1:0] mask;
    mask = PRESC_WIDTH'((32'd1 << sel) - 32'd1);
    return (cnt & mask) == mask;
  endfunction : prescale_hit
  // Byte-lane merge of a written word into an old value.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wr,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge
  // Strips mode bits that a channel cannot hold.
  function automatic logic [15:0] clean_mode(input int ch,
                                             input logic [15:0] v);
    logic [15:0] res;
    res = v;
    // R1 even masters
    if ((ch % 2) != 0) begin
      res[MODE_MASTER_BIT] = 1'b0;
    end
    // R2 no slave zero
    if (ch == 0) begin
      res[MODE_SLAVE_BIT] = 1'b0;
    end
    // R14 split channels only
    if (ch != 1 && ch != 3) begin
      res[MODE_SPLIT_BIT] = 1'b0;
    end
    return res;
  endfunction : clean_mode
  // Register read decode; the flag marks an unmapped address.
  function automatic logic [32:0] reg_read(input tcg_state_type s,
                                           input logic [7:0] addr);
    logic [31:0] v;
    logic [3:0] idx;
    v = 32'h0000_0000;
    idx = addr[5:2];
    if (addr >= ADDR_LIMIT) begin
      return {1'b1, 32'h0000_0000};
    end
    if (addr[7:2] == ADDR_STATUS[7:2]) begin
      for (int i = 0; i < NUM_CH; i++) begin
        v[i] = s.phase[i] != PH_IDLE;
        v[UPPER_LSB + i] = s.uphase[i] != PH_IDLE;
      end
    end else if (addr[7:2] == ADDR_PRESCALE[7:2]) begin
      v[7:0] = s.psel;
    end else if (addr[7:4] == ADDR_MODE0[7:4]) begin
      v[15:0] = s.mode[idx[1:0]];
    end else if (addr[7:4] == ADDR_DATA0[7:4]) begin
      v[15:0] = s.data[idx[1:0]];
    end else if (addr[7:4] == ADDR_COUNT0[7:4]) begin
      v[15:0] = s.count[idx[1:0]];
      v[15:8] = s.mode[idx[1:0]][MODE_SPLIT_BIT] ?
                s.ucount[idx[1:0]] : s.count[idx[1:0]][15:8];
    end
    return {1'b0, v};
  endfunction : reg_read
  // Tick routing and group decode, filled by the process below.
  logic [1:0] clk_tick;
  logic [NUM_CH-1:0] mck;
  logic [NUM_CH-1:0] ptick;
  logic [NUM_CH-1:0] own_tick;
  logic [NUM_CH-1:0] eff_start;
  logic [NUM_CH-1:0] src_tick;
  logic [NUM_CH-1:0] is_slave;
  logic [1:0] mst [NUM_CH];
  logic split;
  logic zero;
  // Next-state logic for bus, dividers, pins and counters.
  always_comb begin
    logic do_write;
    logic [32:0] rd;
    logic [31:0] wmask;
    logic [NUM_CH-1:0] start_w;
    logic [NUM_CH-1:0] stop_w;
    logic [NUM_CH-1:0] ustart_w;
    logic [NUM_CH-1:0] ustop_w;
    do_write = 1'b0;
    rd = 33'h0_0000_0000;
    wmask = 32'h0000_0000;
    start_w = '0;
    stop_w = '0;
    ustart_w = '0;
    ustop_w = '0;
    st_next = st_reg;
    st_next.irq = '0;
    st_next.uirq = '0;
    // Write address and data are taken in either order.
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    do_write = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    if (do_write) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      wmask = merge(32'h0000_0000, st_reg.wdata, st_reg.wstrb);
      if (st_reg.awaddr >= ADDR_LIMIT) begin
        st_next.bresp = RESP_SLVERR;
      end else if (st_reg.awaddr[7:2] == ADDR_START[7:2]) begin
        start_w = wmask[NUM_CH-1:0];
        ustart_w = wmask[UPPER_LSB +: NUM_CH];
      end else if (st_reg.awaddr[7:2] == ADDR_STOP[7:2]) begin
        stop_w = wmask[NUM_CH-1:0];
        ustop_w = wmask[UPPER_LSB +: NUM_CH];
      end else if (st_reg.awaddr[7:2] == ADDR_PRESCALE[7:2]) begin
        st_next.psel = 8'(merge({24'h00_0000, st_reg.psel}, st_reg.wdata,
                                st_reg.wstrb));
      end else if (st_reg.awaddr[7:4] == ADDR_MODE0[7:4]) begin
        st_next.mode[st_reg.awaddr[3:2]] = clean_mode(
          int'(st_reg.awaddr[3:2]),
          16'(merge({16'h0000, st_reg.mode[st_reg.awaddr[3:2]]},
                    st_reg.wdata, st_reg.wstrb)));
      end else if (st_reg.awaddr[7:4] == ADDR_DATA0[7:4]) begin
        st_next.data[st_reg.awaddr[3:2]] =
          16'(merge({16'h0000, st_reg.data[st_reg.awaddr[3:2]]},
                    st_reg.wdata, st_reg.wstrb));
      end
    end

    // Read channel answers one cycle after the address is taken.
    if (s_axi_arvalid && st_reg.arready) begin
      rd = reg_read(st_reg, s_axi_araddr);
      st_next.rvalid = 1'b1;
      st_next.rdata = rd[31:0];
      st_next.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
    // R21 prescaled ticks
    st_next.presc = st_reg.presc + PRESC_WIDTH'(1);
    clk_tick[0] = prescale_hit(st_reg.presc, st_reg.psel[PSEL0_LSB +: 4]);
    clk_tick[1] = prescale_hit(st_reg.presc, st_reg.psel[PSEL1_LSB +: 4]);

    // Pin path: two-flop sync, optional filter, rising edge on mck.
    st_next.sync1 = timer_input_pin;
    st_next.sync2 = st_reg.sync1;
    for (int n = 0; n < NUM_CH; n++) begin
      mck[n] = clk_tick[st_reg.mode[n][MODE_CLK_SEL_BIT]];
      if (mck[n]) begin
        st_next.prv[n] = st_reg.sync2[n];
        st_next.acc_d[n] = st_reg.acc[n];
        // R24 two-sample filter
        if (!st_reg.mode[n][MODE_FILTER_BIT] ||
            st_reg.sync2[n] == st_reg.prv[n]) begin
          st_next.acc[n] = st_reg.sync2[n];
        end
      end
      // R23 pin edge tick
      ptick[n] = mck[n] && st_reg.acc[n] && !st_reg.acc_d[n] &&
                 st_reg.phase[n] != PH_IDLE;
      own_tick[n] = st_reg.mode[n][MODE_CSS_BIT] ? ptick[n] : mck[n];
    end

    // R7 R13 nearest lower master
    for (int n = 0; n < NUM_CH; n++) begin
      mst[n] = 2'd0;
      is_slave[n] = 1'b0;
      // R9 masters take no source
      if (st_reg.mode[n][MODE_SLAVE_BIT] &&
          !st_reg.mode[n][MODE_MASTER_BIT]) begin
        for (int j = 0; j < n; j++) begin
          // R5 nearest master wins
          if ((j % 2) == 0 && st_reg.mode[j][MODE_MASTER_BIT]) begin
            mst[n] = 2'(j);
            is_slave[n] = 1'b1;
          end
        end
      end
    end

    // R8 slaves consume master signals
    for (int n = 0; n < NUM_CH; n++) begin
      // R4 many slaves allowed
      eff_start[n] = start_w[n] || (is_slave[n] && start_w[mst[n]]);
      if (is_slave[n]) begin
        src_tick[n] = st_reg.mode[n][MODE_CSS_BIT] ?
                      st_reg.irq[mst[n]] : own_tick[mst[n]];
      end else begin
        src_tick[n] = own_tick[n];
      end
      // R22 one cycle later
      st_next.tick_d[n] = src_tick[n];
      st_next.utick_d[n] = mck[n];
    end

    // R20 R25 counters advance on enables
    for (int n = 0; n < NUM_CH; n++) begin
      split = st_reg.mode[n][MODE_SPLIT_BIT];
      zero = split ? (st_reg.count[n][7:0] == 8'h00)
                   : (st_reg.count[n] == 16'h0000);
      // R17 lower half controls
      if (stop_w[n]) begin
        st_next.phase[n] = PH_IDLE;
      end else if (eff_start[n]) begin
        if (st_reg.mode[n][MODE_CSS_BIT] && !is_slave[n]) begin
          st_next.count[n] = st_reg.data[n];
          st_next.phase[n] = PH_COUNT;
        end else begin
          st_next.phase[n] = PH_WAIT;
        end
      end else if (st_reg.tick_d[n]) begin
        case (st_reg.phase[n])
          PH_WAIT: begin
            st_next.count[n] = st_reg.data[n];
            st_next.phase[n] = PH_COUNT;
            st_next.irq[n] = st_reg.mode[n][MODE_START_IRQ_BIT];
          end
          PH_COUNT: begin
            if (zero) begin
              st_next.count[n] = st_reg.data[n];
              st_next.irq[n] = 1'b1;
            end else if (split) begin
              st_next.count[n][7:0] = st_reg.count[n][7:0] - 8'h01;
            end else begin
              st_next.count[n] = st_reg.count[n] - 16'h0001;
            end
          end
          default: begin
            st_next.phase[n] = PH_IDLE;
          end
        endcase
      end

      // R18 upper ignored unsplit
      if (split) begin
        // R16 own upper controls
        if (ustop_w[n]) begin
          st_next.uphase[n] = PH_IDLE;
        end else if (ustart_w[n]) begin
          st_next.uphase[n] = PH_WAIT;
        end else if (st_reg.utick_d[n]) begin
          case (st_reg.uphase[n])
            PH_WAIT: begin
              // R15 interrupt at start
              st_next.ucount[n] = st_reg.data[n][15:8];
              st_next.uphase[n] = PH_COUNT;
              st_next.uirq[n] = 1'b1;
            end
            PH_COUNT: begin
              if (st_reg.ucount[n] == 8'h00) begin
                st_next.ucount[n] = st_reg.data[n][15:8];
                st_next.uirq[n] = 1'b1;
              end else begin
                st_next.ucount[n] = st_reg.ucount[n] - 8'h01;
              end
            end
            default: begin
              st_next.uphase[n] = PH_IDLE;
            end
          endcase
        end
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign channel_interrupt_request = st_reg.irq;
  assign ch1_upper_half_interrupt = st_reg.uirq[1];
  assign ch3_upper_half_interrupt = st_reg.uirq[3];
endmodule : tcg_timer_group

/* include/tcg_pkg.sv */
// Operation
// R1: Only channels 0 and 2 may be masters.
// R2: Every channel except 0 may be slave.
// R3: Software puts slaves above their master.
// R4: One master may drive several slaves.
// R5: Software never skips another master for slaves.
// R6: Software matches slave clock select to master.
// R7: Master forwards interrupt, start and tick upward.
// R8: Slaves consume master signals, never forward own.
// R9: Masters never take another master's signals.
// R10: Software starts a group in one write.
// R11: Software never retriggers slave starts alone.
// R12: Software stops a group in one write.
// R13: Grouping acts only inside one group.
// R14: Only channels 1 and 3 split into halves.
// R15: Upper half interrupts at start, interval only.
// R16: Upper half uses own clock, start, stop.
// R17: Lower half uses normal start, stop, status.
// R18: Upper triggers ignored while running 16-bit.
// R19: Software avoids split channel group and reads.
// R20: Split lower half may be a slave.
// R21: Prescaled tick divides by one to 2^15.
// R22: Counter updates one cycle after tick.
// R23: Pin edge tick after start, synchronised.
// R24: Filter accepts level stable two samples.
// R25: Tick is an enable, not a clock.
package tcg_pkg;
  localparam int NUM_CH = 4;
  localparam int PRESC_WIDTH = 15;
  localparam int ADDR_WIDTH = 8;
  // Register byte offsets.
  localparam logic [7:0] ADDR_START = 8'h00;
  localparam logic [7:0] ADDR_STOP = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE = 8'h0C;
  localparam logic [7:0] ADDR_MODE0 = 8'h10;
  localparam logic [7:0] ADDR_DATA0 = 8'h20;
  localparam logic [7:0] ADDR_COUNT0 = 8'h30;
  localparam logic [7:0] ADDR_LIMIT = 8'h40;
  // Fields of the trigger, status and prescale words.
  localparam int UPPER_LSB = 8;
  localparam int PSEL0_LSB = 0;
  localparam int PSEL1_LSB = 4;
  // Fields of each channel mode word.
  localparam int MODE_CLK_SEL_BIT = 15;
  localparam int MODE_CSS_BIT = 12;
  localparam int MODE_MASTER_BIT = 11;
  localparam int MODE_SPLIT_BIT = 10;
  localparam int MODE_SLAVE_BIT = 9;
  localparam int MODE_FILTER_BIT = 8;
  localparam int MODE_START_IRQ_BIT = 0;
  // Reset values.
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [7:0] PSEL_RESET = 8'h00;
  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Counter phases.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_COUNT = 2'b10
  } tcg_phase_type;
endpackage : tcg_pkg

/* verification/tcg_pin_drv.sv */
`timescale 1ns/1ps
module tcg_pin_drv (
  input wire logic aclk,
  output logic [3:0] pin
);
  initial pin = 4'h0;
  // pin edges per channel.
  // Raises one pin, holds it, then keeps it low for a while.
  task automatic pulse(input int ch, input int hi, input int lo);
    pin[ch] <= 1'b1;
    repeat (hi) @(posedge aclk);
    pin[ch] <= 1'b0;
    repeat (lo) @(posedge aclk);
  endtask : pulse
endmodule : tcg_pin_drv

/* verification/tcg_timer_group_sva.sv */
`timescale 1ns/1ps
module tcg_timer_group_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] channel_interrupt_request,
  input wire logic ch1_upper_half_interrupt,
  input wire logic ch3_upper_half_interrupt
);
  import tcg_pkg::*;
  logic [5:0] irqv;
  // All interrupt lines seen as one vector.
  assign irqv = {ch3_upper_half_interrupt, ch1_upper_half_interrupt,
                 channel_interrupt_request};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("late read data");
  AST_W_TIME: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer off time");
  AST_W_BLOCK: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready while bvalid");
  // read address ready returns the cycle after the handshake
  AST_R_BACK: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("arready not back");
  AST_ERR_ZERO: assert property (s_axi_rvalid &&
    s_axi_rresp != RESP_OKAY |-> s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0000_0000) else $error("bad refused read");
  AST_IRQ_PULSE: assert property (irqv != 6'h00 |=>
    (irqv & $past(irqv)) == 6'h00) else $error("interrupt too long");
  AST_RST_OUT: assert property ($rose(aresetn) |->
    irqv == 6'h00 && !s_axi_awready && !s_axi_bvalid &&
    !s_axi_rvalid) else $error("output set after reset");
endmodule : tcg_timer_group_sva
bind tcg_timer_group tcg_timer_group_sva u_sva (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .channel_interrupt_request, .ch1_upper_half_interrupt,
  .ch3_upper_half_interrupt);

/* verification/tcg_timer_group_tb.sv */
`timescale 1ns/1ps
module tcg_timer_group_tb;
  import tcg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] timer_input_pin, channel_interrupt_request;
  logic ch1_upper_half_interrupt, ch3_upper_half_interrupt;
  wire [5:0] irqv = {ch3_upper_half_interrupt, ch1_upper_half_interrupt,
                     channel_interrupt_request};
  int fails = 0;
  int n_compared = 0;
  int seed = 34834;
  int exp_q[$];
  // Clock of 25 ns.
  always #12.5 aclk = ~aclk;
  tcg_timer_group u_tcg_timer_group (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_input_pin, .channel_interrupt_request,
    .ch1_upper_half_interrupt, .ch3_upper_half_interrupt);
  tcg_pin_drv u_tcg_pin_drv (.aclk, .pin(timer_input_pin));
  task automatic report_and_stop;
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic tmo;
    fails++;
    $display("CHECK FAILED %0t wait ran out", $time);
    report_and_stop();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Clock cycles per period of a reloading down counter.
  function automatic int per(input int d, input int k);
    return (d + 1) << k;
  endfunction : per
  // One register write; each channel is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    if (i == 50) tmo();
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask : wr
  // One register read compared with the expected word.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    if (i == 50) tmo();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
  endtask : rd
  // Cycles until the next pulse on one interrupt line.
  task automatic wirq(input int b, output int t);
    for (t = 1; t < 3000; t++) begin
      @(posedge aclk);
      if (irqv[b] === 1'b1) return;
    end
    tmo();
  endtask : wirq
  // Watchdog against a hang anywhere.
  initial begin
    repeat (90000) @(posedge aclk);
    tmo();
  end
  // Main sequence.
  initial begin
    int k, d0, n, t;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_MODE0, 32'(MODE_RESET), RESP_OKAY);
    rd(ADDR_LIMIT, 32'h0000_0000, RESP_SLVERR);
    wr(ADDR_LIMIT, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_MODE0 + 8'h04, 32'h0000_0800, RESP_OKAY);
    rd(ADDR_MODE0 + 8'h04, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_MODE0, 32'h0000_0600, RESP_OKAY);
    rd(ADDR_MODE0, 32'h0000_0000, RESP_OKAY);
    k = $unsigned($random(seed)) % 4;
    d0 = 2 + $unsigned($random(seed)) % 8;
    exp_q.push_back(per(d0, k));
    exp_q.push_back(per(d0 + 1, k));
    exp_q.push_back(per(3, k));
    wr(ADDR_PRESCALE, 32'(k), RESP_OKAY);
    wr(ADDR_DATA0, 32'(d0), RESP_OKAY);
    wr(ADDR_DATA0 + 8'h04, 32'(d0 + 1), RESP_OKAY);
    // group of master 0 and slave 1 on one clock
    wr(ADDR_MODE0, 32'h0000_0801, RESP_OKAY);
    wr(ADDR_MODE0 + 8'h04, 32'h0000_0201, RESP_OKAY);
    wr(ADDR_START, 32'h0000_0003, RESP_OKAY);
    wirq(0, t);
    wirq(0, t);
    chk(32'(t), 32'(exp_q.pop_front()));
    wirq(1, t);
    wirq(1, t);
    chk(32'(t), 32'(exp_q.pop_front()));
    wr(ADDR_START, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0003, RESP_OKAY);
    wr(ADDR_STOP, 32'h0000_0003, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    // split channel used alone, upper count not read
    wr(ADDR_MODE0 + 8'h04, 32'h0000_0400, RESP_OKAY);
    wr(ADDR_DATA0 + 8'h04, 32'h0000_0302, RESP_OKAY);
    wr(ADDR_START, 32'h0000_0200, RESP_OKAY);
    wirq(4, t);
    wirq(4, t);
    chk(32'(t), 32'(exp_q.pop_front()));
    rd(ADDR_STATUS, 32'h0000_0200, RESP_OKAY);
    wr(ADDR_STOP, 32'h0000_0200, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_START, 32'h0000_0800, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    // channel 2 counts pin edges on its own
    wr(ADDR_MODE0 + 8'h08, 32'h0000_9100, RESP_OKAY);
    wr(ADDR_DATA0 + 8'h08, 32'h0000_0064, RESP_OKAY);
    wr(ADDR_START, 32'h0000_0004, RESP_OKAY);
    rd(ADDR_COUNT0 + 8'h08, 32'h0000_0064, RESP_OKAY);
    n = 1 + $unsigned($random(seed)) % 4;
    repeat (n) u_tcg_pin_drv.pulse(2, 4, 4);
    repeat (2) u_tcg_pin_drv.pulse(2, 1, 4);
    rd(ADDR_COUNT0 + 8'h08, 32'(100 - n), RESP_OKAY);
    wr(ADDR_STOP, 32'h0000_0004, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    // master 2 drives split slave 3 through its interrupt
    wr(ADDR_MODE0 + 8'h08, 32'h0000_0801, RESP_OKAY);
    wr(ADDR_DATA0 + 8'h08, 32'h0000_0001, RESP_OKAY);
    wr(ADDR_MODE0 + 8'h0C, 32'h0000_1600, RESP_OKAY);
    wr(ADDR_DATA0 + 8'h0C, 32'h0000_0201, RESP_OKAY);
    wr(ADDR_START, 32'h0000_080C, RESP_OKAY);
    wirq(2, t);
    wirq(2, t);
    chk(32'(t), 32'(per(1, k)));
    wirq(3, t);
    wirq(3, t);
    chk(32'(t), 32'(2 * per(1, k)));
    wirq(5, t);
    wirq(5, t);
    chk(32'(t), 32'(per(2, k)));
    wr(ADDR_STOP, 32'h0000_080C, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    report_and_stop();
  end
endmodule : tcg_timer_group_tb
